// ==== logic/relay_regs.vh ====
// register map, field positions, reset values and timing of the relay channel
`ifndef RELAY_REGS_VH
`define RELAY_REGS_VH

// ==========================================================
// register byte offsets
`define REG_CTRL        8'h00
`define REG_DLY_ON      8'h04
`define REG_DLY_OFF     8'h08
`define REG_STAIR_TIME  8'h0C
`define REG_FLASH_ON    8'h10
`define REG_FLASH_OFF   8'h14
`define REG_STATUS      8'h18

// ==========================================================
// control register fields
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_POL        2
`define CTRL_FB_LO      3
`define CTRL_FB_HI      4
`define CTRL_STOP_EN    5
`define CTRL_SDLY_EN    6
`define CTRL_W          7

// operating modes
`define MODE_SWITCH     2'h0
`define MODE_DELAY      2'h1
`define MODE_STAIRS     2'h2
`define MODE_FLASH      2'h3

// status feedback policies
`define FB_OFF          2'h0
`define FB_CHANGE       2'h1
`define FB_DEMAND       2'h2
`define FB_CHG_START    2'h3

// ==========================================================
// reset values
`define CTRL_RST        7'h00
`define DLY_ON_RST      16'h0000
`define DLY_OFF_RST     16'h0000
`define STAIR_RST       16'h0BB8
`define FLASH_ON_RST    16'h01F4
`define FLASH_OFF_RST   16'h01F4

// ==========================================================
// timing: clock period and time-base tick, both in ns
`define CLK_PERIOD_NS   4
`define TICK_NS         1000000
`define TICK_CYCLES     (`TICK_NS / `CLK_PERIOD_NS)

`endif

// ==== logic/tick_divider.v ====
// time-base divider producing a one-cycle tick enable
`timescale 1ns/1ns

module tick_divider #(
  parameter CYCLES = 250000
) (
  input  wire clk_i,
  input  wire rst_i,
  output reg  tick_o
);

  reg [31:0] count;

  // ==========================================================
  // divider: one enable pulse every CYCLES clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      count  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (count >= CYCLES[31:0] - 32'h0000_0001) begin
      count  <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end

endmodule // tick_divider

// ==== logic/phase_timer.v ====
// reloadable down counter of time-base ticks with a done pulse
`timescale 1ns/1ns

module phase_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        tick_i,
  input  wire        load_i,
  input  wire [15:0] value_i,
  input  wire        cancel_i,
  output reg         busy_o,
  output reg         done_o
);

  reg [15:0] count;

  // ==========================================================
  // load beats cancel and tick; a value of 0 or 1 ends at the next tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      count  <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        count  <= value_i;
        busy_o <= 1'b1;
      end else if (cancel_i) begin
        busy_o <= 1'b0;
      end else if (tick_i && busy_o) begin
        if (count <= 16'h0001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end

endmodule // phase_timer

// ==== logic/relay_channel_mode_controller.v ====
// one relay channel: mode engine, overrides, status feedback, wishbone regs
//
// How it works
// [RULE1] switching mode: relay follows each command at once
// [RULE2] delay mode holds separate activate and deactivate delays
// [RULE3] stairs mode: activate closes relay, on-time expiry opens it
// [RULE4] stairs stop enabled: stop cancels on-time and opens relay at once
// [RULE5] stairs mode may wait a configurable delay before closing
// [RULE6] flash mode cycles on-time and off-time after enable until disabled
// [RULE7] disabling flash leaves the relay as it stood at that moment
// [RULE8] polarity zero: 0 activates, 1 returns contact to normal
// [RULE9] delay mode closes only after activate delay; opposite value opens
// [RULE10] stairs mode: non-activating value while running stops and opens
// [RULE11] flash mode: activating value starts, opposite value ends flashing
// [RULE12] polarity one swaps the roles of received 1 and 0
// [RULE13] feedback off: never send status
// [RULE14] feedback on change: send status on every contact change
// [RULE15] feedback on demand: answer a read request with current status
// [RULE16] change and startup: send at startup and on every change
// [RULE17] status bit is 1 with contact closed, 0 with contact normal
// [RULE18] with a delay, status goes out when relay switches, not earlier
// [RULE19] flashing: status follows every on and off phase
// [RULE20] status comes from contact position, never from polarity
// [RULE21] block over priority over safety over ordinary switching
// [RULE22] all times count a common tick, reloaded at every start
// [RULE23] a mode change cancels any running timer
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "relay_regs.vh"

module relay_channel_mode_controller #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // switching telegram and status requests from the bus stack
  input  wire        cmd_valid_i,
  input  wire        cmd_value_i,
  input  wire        read_req_i,
  input  wire        startup_i,
  // higher-priority functions
  input  wire        block_active_i,
  input  wire        block_state_i,
  input  wire        prio_active_i,
  input  wire        prio_state_i,
  input  wire        safety_active_i,
  input  wire        safety_state_i,
  // relay and status telegram
  output reg         relay_o,
  output reg         status_valid_o,
  output reg         status_value_o,
  output reg         status_resp_o
);

  // ==========================================================
  // engine states
  localparam [5:0] S_IDLE      = 6'h01;
  localparam [5:0] S_WAIT_ON   = 6'h02;
  localparam [5:0] S_WAIT_OFF  = 6'h04;
  localparam [5:0] S_STAIR     = 6'h08;
  localparam [5:0] S_FLASH_ON  = 6'h10;
  localparam [5:0] S_FLASH_OFF = 6'h20;

  // ==========================================================
  // helper functions
  // a telegram activates when its value equals the polarity setting
  function is_activate;
    input value;
    input pol;
    begin
      is_activate = (value == pol); // RULE8 RULE12
    end
  endfunction

  // byte-lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
      merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  // ==========================================================
  // declarations
  reg  [`CTRL_W-1:0] ctrl;
  reg  [15:0]        dly_on, dly_off, stair_time;
  reg  [15:0]        flash_on, flash_off, tmr_val;
  reg  [5:0]         state, next_state;
  reg                relay_core, next_relay, tmr_load, tmr_cancel;
  reg  [31:0]        rd_data;
  wire               tick, tmr_busy, tmr_done, req, wr_commit, eff_relay;
  wire               ctrl_wr, mode_chg, pol, stop_en, sdly_en, override;
  wire               cmd_ok, act, deact, flashing, changed;
  wire [1:0]         mode, fb;

  assign mode     = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign fb       = ctrl[`CTRL_FB_HI:`CTRL_FB_LO];
  assign pol      = ctrl[`CTRL_POL];
  assign stop_en  = ctrl[`CTRL_STOP_EN];
  assign sdly_en  = ctrl[`CTRL_SDLY_EN];
  assign flashing = (state == S_FLASH_ON) || (state == S_FLASH_OFF);

  // ==========================================================
  // time base and the single shared phase timer
  tick_divider #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // one timer is enough: at most one delay or phase runs at a time
  phase_timer u_tmr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .load_i   (tmr_load),
    .value_i  (tmr_val),
    .cancel_i (tmr_cancel),
    .busy_o   (tmr_busy),
    .done_o   (tmr_done)
  );

  // ==========================================================
  // wishbone slave: ack one cycle after the request, dropped next cycle
  assign req       = wb_cyc_i && wb_stb_i;
  assign wr_commit = req && wb_ack_o && wb_we_i;
  assign ctrl_wr   = wr_commit && (wb_adr_i == `REG_CTRL) && wb_sel_i[0];
  assign mode_chg  = ctrl_wr &&
                     (wb_dat_i[`CTRL_MODE_HI:`CTRL_MODE_LO] != mode);

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `REG_CTRL:       rd_data[`CTRL_W-1:0] = ctrl;
      `REG_DLY_ON:     rd_data[15:0] = dly_on;
      `REG_DLY_OFF:    rd_data[15:0] = dly_off;
      `REG_STAIR_TIME: rd_data[15:0] = stair_time;
      `REG_FLASH_ON:   rd_data[15:0] = flash_on;
      `REG_FLASH_OFF:  rd_data[15:0] = flash_off;
      `REG_STATUS:     rd_data[4:0]  = {override, tmr_busy,
                                        (state == S_STAIR),
                                        flashing, relay_o};
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // handshake and read data capture
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= (req && !wb_ack_o) ? rd_data : wb_dat_o;
    end
  end

  // writes land on the edge where the master sees ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl       <= `CTRL_RST;
      dly_on     <= `DLY_ON_RST;
      dly_off    <= `DLY_OFF_RST;
      stair_time <= `STAIR_RST;
      flash_on   <= `FLASH_ON_RST;
      flash_off  <= `FLASH_OFF_RST;
    end else if (wr_commit) begin
      case (wb_adr_i)
        `REG_CTRL:       ctrl <= wb_sel_i[0] ? wb_dat_i[`CTRL_W-1:0] : ctrl;
        `REG_DLY_ON:     dly_on     <= merge16(dly_on, wb_dat_i, wb_sel_i);
        `REG_DLY_OFF:    dly_off    <= merge16(dly_off, wb_dat_i, wb_sel_i);
        `REG_STAIR_TIME: stair_time <= merge16(stair_time, wb_dat_i,
                                               wb_sel_i);
        `REG_FLASH_ON:   flash_on   <= merge16(flash_on, wb_dat_i, wb_sel_i);
        `REG_FLASH_OFF:  flash_off  <= merge16(flash_off, wb_dat_i,
                                               wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // command qualification
  // ordinary switching is ignored while any higher function holds
  assign override = block_active_i || prio_active_i || safety_active_i;
  assign cmd_ok   = cmd_valid_i && !override; // RULE21
  assign act      = cmd_ok && is_activate(cmd_value_i, pol);
  assign deact    = cmd_ok && !is_activate(cmd_value_i, pol);

  // ==========================================================
  // mode engine: next state, next relay and timer control
  always @* begin
    next_state = state;
    next_relay = relay_core;
    tmr_load   = 1'b0;
    tmr_val    = 16'h0000;
    tmr_cancel = 1'b0;
    if (mode_chg) begin
      // a stale timer must not act under the new mode
      tmr_cancel = 1'b1; // RULE23
      next_state = S_IDLE;
    end else if (act) begin
      case (mode)
        `MODE_SWITCH: begin
          next_relay = 1'b1; // RULE1
          next_state = S_IDLE;
        end
        `MODE_DELAY: begin
          tmr_load   = 1'b1; // RULE2 RULE9 RULE22
          tmr_val    = dly_on;
          next_state = S_WAIT_ON;
        end
        `MODE_STAIRS: begin
          if (sdly_en) begin
            tmr_load   = 1'b1; // RULE5
            tmr_val    = dly_on;
            next_state = S_WAIT_ON;
          end else begin
            // retrigger while running restarts the on-time
            next_relay = 1'b1; // RULE3
            tmr_load   = 1'b1;
            tmr_val    = stair_time;
            next_state = S_STAIR;
          end
        end
        default: begin
          if (!flashing) begin
            next_relay = 1'b1; // RULE6 RULE11
            tmr_load   = 1'b1;
            tmr_val    = flash_on;
            next_state = S_FLASH_ON;
          end
        end
      endcase
    end else if (deact) begin
      case (mode)
        `MODE_SWITCH: begin
          next_relay = 1'b0; // RULE1
          next_state = S_IDLE;
        end
        `MODE_DELAY: begin
          tmr_load   = 1'b1; // RULE2 RULE9
          tmr_val    = dly_off;
          next_state = S_WAIT_OFF;
        end
        `MODE_STAIRS: begin
          if (stop_en &&
              ((state == S_STAIR) || (state == S_WAIT_ON))) begin
            next_relay = 1'b0; // RULE4 RULE10
            tmr_cancel = 1'b1;
            next_state = S_IDLE;
          end
        end
        default: begin
          if (flashing) begin
            // relay keeps whatever phase it was in
            tmr_cancel = 1'b1; // RULE7 RULE11
            next_state = S_IDLE;
          end
        end
      endcase
    end else if (tmr_done) begin
      case (state)
        S_WAIT_ON: begin
          next_relay = 1'b1; // RULE9 RULE5
          if (mode == `MODE_STAIRS) begin
            tmr_load   = 1'b1; // RULE3
            tmr_val    = stair_time;
            next_state = S_STAIR;
          end else begin
            next_state = S_IDLE;
          end
        end
        S_WAIT_OFF: begin
          next_relay = 1'b0; // RULE9
          next_state = S_IDLE;
        end
        S_STAIR: begin
          next_relay = 1'b0; // RULE3
          next_state = S_IDLE;
        end
        S_FLASH_ON: begin
          next_relay = 1'b0; // RULE6
          tmr_load   = 1'b1;
          tmr_val    = flash_off;
          next_state = S_FLASH_OFF;
        end
        S_FLASH_OFF: begin
          next_relay = 1'b1; // RULE6
          tmr_load   = 1'b1;
          tmr_val    = flash_on;
          next_state = S_FLASH_ON;
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  // engine registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state      <= S_IDLE;
      relay_core <= 1'b0;
    end else begin
      state      <= next_state;
      relay_core <= next_relay;
    end
  end

  // ==========================================================
  // priority resolution onto the contact
  assign eff_relay = block_active_i  ? block_state_i  : // RULE21
                     prio_active_i   ? prio_state_i   :
                     safety_active_i ? safety_state_i : relay_core;

  // the telegram leaves on the edge the contact moves, not on the command
  assign changed = (eff_relay != relay_o); // RULE18 RULE19

  // ==========================================================
  // contact drive and status telegram
  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_o        <= 1'b0;
      status_valid_o <= 1'b0;
      status_value_o <= 1'b0;
      status_resp_o  <= 1'b0;
    end else begin
      relay_o        <= eff_relay;
      // value mirrors the contact, polarity plays no part
      status_value_o <= eff_relay; // RULE17 RULE20
      status_resp_o  <= read_req_i && (fb == `FB_DEMAND); // RULE15
      case (fb)
        `FB_CHANGE: begin
          status_valid_o <= changed; // RULE14
        end
        `FB_DEMAND: begin
          status_valid_o <= read_req_i; // RULE15
        end
        `FB_CHG_START: begin
          status_valid_o <= changed || startup_i; // RULE16
        end
        default: begin
          status_valid_o <= 1'b0; // RULE13
        end
      endcase
    end
  end

endmodule // relay_channel_mode_controller

// ==== sim/relay_channel_monitor.sv ====
// checker: bus handshake, switching, feedback and override timing
`timescale 1ns/1ns
`include "relay_regs.vh"

module relay_channel_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        cmd_valid_i,
  input wire        cmd_value_i,
  input wire        read_req_i,
  input wire        startup_i,
  input wire        block_active_i,
  input wire        block_state_i,
  input wire        prio_active_i,
  input wire        prio_state_i,
  input wire        safety_active_i,
  input wire        relay_o,
  input wire        status_valid_o,
  input wire        status_value_o,
  input wire        status_resp_o
);
  // ==========================================================
  // shadow of control; taken at the accepting edge, as the slave does
  logic [6:0] ctrl;
  logic       want;
  wire        ovr = block_active_i | prio_active_i | safety_active_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RST;
      want <= 1'h0;
    end else begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
          && wb_adr_i == `REG_CTRL)
        ctrl <= wb_dat_i[6:0];
      if (cmd_valid_i)
        want <= (cmd_value_i == ctrl[`CTRL_POL]);
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // overrides are checked once held for 3 cycles; the relay obeys them one cycle later
  sequence s_blocked;
    block_active_i [*3];
  endsequence
  sequence s_prio;
    (prio_active_i && !block_active_i) [*3];
  endsequence

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_switch_follows: assert property (
    ctrl[1:0] == `MODE_SWITCH && cmd_valid_i && !ovr
    |=> ##[0:1] relay_o == want) else $error("relay ignored command");
  a_status_is_contact: assert property (
    status_valid_o |-> status_value_o == relay_o)
    else $error("status bit differs from contact");
  a_change_reported: assert property (
    ctrl[`CTRL_FB_LO] && $changed(relay_o) |-> status_valid_o
    && !status_resp_o) else $error("contact change not reported");
  a_off_is_silent: assert property (
    ctrl[4:3] == `FB_OFF |-> !status_valid_o)
    else $error("status sent with feedback off");
  a_demand_answer: assert property (
    ctrl[4:3] == `FB_DEMAND && read_req_i |=> status_valid_o
    && status_resp_o) else $error("read request not answered");
  a_resp_only_demand: assert property (
    status_resp_o |-> status_valid_o && ctrl[4:3] == `FB_DEMAND)
    else $error("response outside demand policy");
  a_startup_sent: assert property (
    ctrl[4:3] == `FB_CHG_START && startup_i |=> status_valid_o)
    else $error("no status at start-up");
  a_block_wins: assert property (
    s_blocked |-> relay_o == $past(block_state_i, 2))
    else $error("block not obeyed");
  a_prio_next: assert property (
    s_prio |-> relay_o == $past(prio_state_i, 2))
    else $error("priority not obeyed");
endmodule // relay_channel_monitor

bind relay_channel_mode_controller relay_channel_monitor
  u_relay_channel_monitor (.*);

// ==== sim/knx_peer_model.sv ====
// bus peer model: group telegrams, status reads and start-up events
`timescale 1ns/1ns

module knx_peer_model (
  input  wire  clk_i,
  output logic cmd_valid_o,
  output logic cmd_value_o,
  output logic read_req_o,
  output logic startup_o
);
  // ==========================================================
  // idle levels; every event is a one-clock pulse
  initial begin
    cmd_valid_o = 1'h0;
    cmd_value_o = 1'h0;
    read_req_o  = 1'h0;
    startup_o   = 1'h0;
  end
  // released data line shows the inverse, so a stale bit never matches
  task send(input logic v);
    @(posedge clk_i);
    cmd_valid_o <= 1'h1;
    cmd_value_o <= v;
    @(posedge clk_i);
    cmd_valid_o <= 1'h0;
    cmd_value_o <= ~v;
  endtask
  // the peer opens the read; the device only answers it
  task read_status();
    @(posedge clk_i);
    read_req_o <= 1'h1;
    @(posedge clk_i);
    read_req_o <= 1'h0;
  endtask
  task power_up();
    @(posedge clk_i);
    startup_o <= 1'h1;
    @(posedge clk_i);
    startup_o <= 1'h0;
  endtask
endmodule // knx_peer_model

// ==== sim/tb_top.sv ====
// top-level bench for the relay channel controller
`timescale 1ns/1ns
`include "relay_regs.vh"

module tb_top;
  localparam int TK = 8;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, rd, rv;
  logic        block_active_i, block_state_i, prio_active_i, prio_state_i;
  logic        safety_active_i, safety_state_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, relay_o, status_valid_o, status_value_o;
  wire         status_resp_o, cmd_valid_i, cmd_value_i, read_req_i;
  wire         startup_i;
  logic [1:0]  exq[$];
  int          errors = 0, total_checks = 0, seed = 32'h8908_5e56;

  relay_channel_mode_controller #(.TICK_CYCLES(TK))
  u_relay_channel_mode_controller (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_valid_i(cmd_valid_i), .cmd_value_i(cmd_value_i),
    .read_req_i(read_req_i), .startup_i(startup_i),
    .block_active_i(block_active_i), .block_state_i(block_state_i),
    .prio_active_i(prio_active_i), .prio_state_i(prio_state_i),
    .safety_active_i(safety_active_i), .safety_state_i(safety_state_i),
    .relay_o(relay_o), .status_valid_o(status_valid_o),
    .status_value_o(status_value_o), .status_resp_o(status_resp_o));
  knx_peer_model u_knx_peer_model (
    .clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_value_o(cmd_value_i),
    .read_req_o(read_req_i), .startup_o(startup_i));

  // ==========================================================
  // clock, comparison and verdict
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task rl(input logic v);
    chk("relay", relay_o, v);
  endtask
  // bounded wait; a stuck relay ends the run as a mismatch
  task wait_relay(input logic v);
    int n;
    n = 0;
    while (relay_o !== v && n < 4 * TK) begin
      @(posedge clk_i);
      n++;
    end
    if (relay_o !== v) begin
      chk("relay_wait", relay_o, v);
      test_done();
    end
  endtask
  // classic single cycle: hold everything until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      chk("wb_ack", wb_ack_o, 1'h1);
      test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    // junk on idle lanes: the slave must stay deaf without cyc and stb
    {wb_we_i, wb_sel_i, wb_adr_i} <= 13'($random(seed));
    wb_dat_i <= $random(seed);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 4'hF);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000, 4'hF);
    chk($sformatf("reg %h", a), rd, e);
  endtask

  // oldest note {resp, value} is matched to each status telegram
  always @(posedge clk_i) begin
    if (!rst_i && status_valid_o === 1'h1) begin
      if (exq.size() > 0)
        chk("status", {status_resp_o, status_value_o}, exq.pop_front());
      else
        chk("status_extra", 1'h1, 1'h0);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {block_active_i, block_state_i, prio_active_i, prio_state_i} = 4'h0;
    {safety_active_i, safety_state_i} = 2'h0;
    tk(3);
    rst_i <= 1'h0;
    rc(`REG_CTRL, `CTRL_RST);
    rc(`REG_DLY_ON, `DLY_ON_RST);
    rc(`REG_DLY_OFF, `DLY_OFF_RST);
    rc(`REG_STAIR_TIME, `STAIR_RST);
    rc(`REG_FLASH_ON, `FLASH_ON_RST);
    rc(`REG_FLASH_OFF, `FLASH_OFF_RST);
    rc(`REG_STATUS, 32'h0000_0000);
    rc(8'h1C, 32'h0000_0000);
    // random times read back in 16 bits; read-only and lane-0 guards
    for (int a = 4; a <= 20; a += 4) begin
      rv = $random(seed);
      wr(a[7:0], rv);
      rc(a[7:0], {16'h0000, rv[15:0]});
      wr(a[7:0], (a == 4) ? 32'h0000_0003 : 32'h0000_0002);
    end
    wr(`REG_STATUS, 32'hFFFF_FFFF);
    rc(`REG_STATUS, 32'h0000_0000);
    wb(1'h1, `REG_CTRL, 32'h0000_007F, 4'h2);
    rc(`REG_CTRL, 32'h0000_0000);
    // switching with both polarities, then two commands back to back
    for (int p = 0; p < 2; p++) begin
      wr(`REG_CTRL, 32'h0000_0008 | (p << 2));
      exq.push_back(2'h1);
      u_knx_peer_model.send(p[0]);
      tk(2);
      rl(1'h1);
      exq.push_back(2'h0);
      u_knx_peer_model.send(!p[0]);
      tk(2);
      rl(1'h0);
    end
    exq.push_back(2'h1);
    exq.push_back(2'h0);
    u_knx_peer_model.send(1'h1);
    u_knx_peer_model.send(1'h0);
    tk(2);
    rl(1'h0);
    // delay mode: 3 ticks on, 2 ticks off; status only once switched
    wr(`REG_CTRL, 32'h0000_0009);
    exq.push_back(2'h1);
    u_knx_peer_model.send(1'h0);
    tk(14);
    rl(1'h0);
    chk("pending", exq.size(), 1);
    wait_relay(1'h1);
    exq.push_back(2'h0);
    u_knx_peer_model.send(1'h1);
    tk(6);
    rl(1'h1);
    wait_relay(1'h0);
    // stairs: timed off, stop command, then with activate delay
    wr(`REG_CTRL, 32'h0000_002A);
    for (int s = 0; s < 3; s++) begin
      if (s == 2)
        wr(`REG_CTRL, 32'h0000_006A);
      exq.push_back(2'h1);
      exq.push_back(2'h0);
      u_knx_peer_model.send(1'h0);
      tk(s == 2 ? 14 : 2);
      rl(s != 2);
      if (s == 1) begin
        u_knx_peer_model.send(1'h1);
        tk(2);
        rl(1'h0);
      end else begin
        wait_relay(1'h1);
      end
      wait_relay(1'h0);
    end
    // flashing phases, disable while on, then cancel a pending delay
    wr(`REG_CTRL, 32'h0000_000B);
    exq.push_back(2'h1);
    u_knx_peer_model.send(1'h0);
    wait_relay(1'h1);
    for (int i = 0; i < 4; i++) begin
      exq.push_back({1'h0, i[0]});
      wait_relay(i[0]);
    end
    u_knx_peer_model.send(1'h1);
    tk(4 * TK);
    rl(1'h1);
    wr(`REG_CTRL, 32'h0000_0009);
    u_knx_peer_model.send(1'h1);
    wr(`REG_CTRL, 32'h0000_0008);
    tk(4 * TK);
    rl(1'h1);
    exq.push_back(2'h0);
    u_knx_peer_model.send(1'h1);
    tk(2);
    rl(1'h0);
    // feedback policies: demand, change plus start-up, off
    wr(`REG_CTRL, 32'h0000_0010);
    exq.push_back(2'h2);
    u_knx_peer_model.read_status();
    u_knx_peer_model.send(1'h0);
    tk(2);
    rl(1'h1);
    exq.push_back(2'h3);
    u_knx_peer_model.read_status();
    tk(2);
    wr(`REG_CTRL, 32'h0000_0018);
    exq.push_back(2'h1);
    u_knx_peer_model.power_up();
    tk(2);
    wr(`REG_CTRL, 32'h0000_0000);
    u_knx_peer_model.send(1'h1);
    u_knx_peer_model.read_status();
    u_knx_peer_model.power_up();
    tk(2);
    rl(1'h0);
    chk("queue", exq.size(), 0);
    // overrides stacked, dropped command, then released one by one
    rv = $random(seed);
    {block_active_i, prio_active_i, safety_active_i} <= 3'h7;
    block_state_i <= rv[0];
    prio_state_i <= !rv[0];
    safety_state_i <= !rv[0];
    tk(3);
    u_knx_peer_model.send(1'h0);
    tk(3);
    rl(rv[0]);
    block_active_i <= 1'h0;
    tk(3);
    rl(!rv[0]);
    prio_active_i <= 1'h0;
    safety_state_i <= rv[0];
    tk(3);
    rl(rv[0]);
    safety_active_i <= 1'h0;
    tk(3);
    rl(1'h0);
    test_done();
  end
endmodule // tb_top
